/* hw/ctpc_top.sv */
// How it works
// RL1 - 31-bit down-counting tick timer with interrupt
// RL2 - Software programs tick interval
// RL3 - 64-bit cycle counter counts every clock
// RL4 - Cycle counter resets to zero
// RL5 - Privileged write loads cycle counter
// RL6 - Anyone reads cycle counter; privileged writes
// RL7 - Four 32-bit performance counters
// RL8 - Per-counter independent event selection
// RL9 - Selected event increments its counter
// RL10 - Counter overflow raises interrupt
// RL11 - Watch comparators report matches as events
// RL12 - Counter wraps; overflow pending until cleared
// RL13 - Tick zero pends until reload or acknowledge; a read of the status register also clears it
`timescale 1ns/1ps
`default_nettype none
module ctpc_top (
	// Clock and reset
	input  wire logic                                         aclk,
	input  wire logic                                         aresetn,
	// AXI4-Lite write address
	input  wire logic [7:0]                                   s_axi_awaddr,
	input  wire logic [2:0]                                   s_axi_awprot,
	input  wire logic                                         s_axi_awvalid,
	output logic                                              s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]                                  s_axi_wdata,
	input  wire logic [3:0]                                   s_axi_wstrb,
	input  wire logic                                         s_axi_wvalid,
	output logic                                              s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                                        s_axi_bresp,
	output logic                                              s_axi_bvalid,
	input  wire logic                                         s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]                                   s_axi_araddr,
	input  wire logic [2:0]                                   s_axi_arprot,
	input  wire logic                                         s_axi_arvalid,
	output logic                                              s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]                                       s_axi_rdata,
	output logic [1:0]                                        s_axi_rresp,
	output logic                                              s_axi_rvalid,
	input  wire logic                                         s_axi_rready,
	// Core event inputs and watched values
	input  wire logic [ctpc_pkg::EVT_N-ctpc_pkg::WATCH_N-1:0] core_events,
	input  wire logic [ctpc_pkg::WATCH_N*ctpc_pkg::WATCH_W-1:0] watch_sample,
	// Interrupt
	output logic                                              irq
);
	import ctpc_pkg::*;

	function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Registers
	logic [TICK_W-1:0]        tick_interval, next_tick_interval;
	logic [TICK_W-1:0]        tick_count, next_tick_count;
	logic                     tick_en, next_tick_en;
	logic [CYC_W-1:0]         cycle, next_cycle;
	logic [IRQ_W-1:0]         irq_status, next_irq_status;
	logic [IRQ_W-1:0]         irq_mask, next_irq_mask;
	logic [SEL_W-1:0]         perf_sel [PERF_N];
	logic [SEL_W-1:0]         next_perf_sel [PERF_N];
	logic [WATCH_W-1:0]       watch_val [WATCH_N];
	logic [WATCH_W-1:0]       next_watch_val [WATCH_N];
	logic [WATCH_W-1:0]       watch_msk [WATCH_N];
	logic [WATCH_W-1:0]       next_watch_msk [WATCH_N];
	logic                     next_irq;
	// Bus state
	ctpc_bus_state_type       wr_state, next_wr_state, rd_state, next_rd_state;
	logic                     aw_got, next_aw_got, w_got, next_w_got;
	logic [7:0]               aw_addr, next_aw_addr;
	logic                     aw_priv, next_aw_priv;
	logic [31:0]              w_data, next_w_data;
	logic [3:0]               w_strb, next_w_strb;
	logic [1:0]               next_bresp, next_rresp;
	logic [31:0]              next_rdata;
	logic                     do_write, do_read;
	// Perf counter wiring
	logic [PERF_W-1:0]        perf_count [PERF_N];
	logic [PERF_N-1:0]        perf_ovf, perf_load;
	logic [EVT_N-1:0]         events;
	ctpc_watch_if             wif ();

	// Watch comparators
	always_comb begin
		wif.sample = watch_sample;
		for (int i = 0; i < WATCH_N; i++) begin
			wif.value[i*WATCH_W +: WATCH_W] = watch_val[i];
			wif.mask[i*WATCH_W +: WATCH_W]  = watch_msk[i];
		end
	end
	ctpc_watch u_watch (
		.aclk    (aclk),
		.aresetn (aresetn),
		.w       (wif.unit)
	);
	assign events = {wif.hit, core_events}; // RL11

	// Performance counters
	for (genvar g = 0; g < PERF_N; g++) begin : g_perf
		ctpc_perf u_perf ( // RL7
			.aclk       (aclk),
			.aresetn    (aresetn),
			.sel        (perf_sel[g]),
			.events     (events),
			.load       (perf_load[g]),
			.load_value (w_data),
			.count      (perf_count[g]),
			.overflow   (perf_ovf[g])
		);
		assign perf_load[g] = do_write && aw_priv && aw_addr == OFF_PERF_CNT0 + 8'(4 * g);
	end

	// Write channel handshake: address and data in either order
	assign do_write = wr_state == CTPC_IDLE && aw_got && w_got && aw_addr[1:0] == 2'h0; // Held halves, aligned only
	always_comb begin
		next_aw_got  = aw_got;
		next_w_got   = w_got;
		next_aw_addr = aw_addr;
		next_aw_priv = aw_priv;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_wr_state = wr_state;
		next_bresp   = s_axi_bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_got  = 1'b1;
			next_aw_addr = s_axi_awaddr;
			next_aw_priv = s_axi_awprot[0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_got  = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		case (wr_state)
			CTPC_IDLE: begin
				if (aw_got && w_got) begin
					next_wr_state = CTPC_RESP;
					next_aw_got   = 1'b0;
					next_w_got    = 1'b0;
					next_bresp    = (aw_addr[1:0] != 2'h0 || aw_addr > OFF_WATCH_MSK0 + 8'hc) ? RESP_SLVERR
						: RESP_OKAY;
				end
			end
			CTPC_RESP: begin
				if (s_axi_bready) begin
					next_wr_state = CTPC_IDLE;
				end
			end
			default: next_wr_state = CTPC_IDLE;
		endcase
	end

	// Read channel
	assign do_read = rd_state == CTPC_IDLE && s_axi_arvalid && s_axi_arready;
	always_comb begin
		next_rd_state = rd_state;
		next_rdata    = s_axi_rdata;
		next_rresp    = s_axi_rresp;
		case (rd_state)
			CTPC_IDLE: begin
				if (s_axi_arvalid) begin
					next_rd_state = CTPC_RESP;
					next_rresp    = RESP_OKAY;
					next_rdata    = 32'h0;
					case (s_axi_araddr)
						OFF_TICK_INTERVAL: next_rdata = {1'b0, tick_interval};
						OFF_TICK_COUNT:    next_rdata = {1'b0, tick_count};
						OFF_TICK_CTRL:     next_rdata = {31'h0, tick_en};
						OFF_CYC_LO:        next_rdata = cycle[31:0]; // RL6
						OFF_CYC_HI:        next_rdata = cycle[63:32]; // RL6
						OFF_IRQ_STATUS:    next_rdata = {23'h0, irq_status};
						OFF_IRQ_MASK:      next_rdata = {23'h0, irq_mask};
						OFF_PRIV_LEVEL:    next_rdata = {31'h0, s_axi_arprot[0]};
						default: begin
							if (s_axi_araddr >= OFF_PERF_CNT0 && s_axi_araddr <= OFF_WATCH_MSK0 + 8'hc
								&& s_axi_araddr[1:0] == 2'h0) begin
								case (s_axi_araddr[5:4])
									2'h2:    next_rdata = perf_count[s_axi_araddr[3:2]];
									2'h3:    next_rdata = {28'h0, perf_sel[s_axi_araddr[3:2]]};
									2'h0:    next_rdata = watch_val[s_axi_araddr[3:2]];
									default: next_rdata = watch_msk[s_axi_araddr[3:2]];
								endcase
							end else begin
								next_rresp = RESP_SLVERR;
							end
						end
					endcase
				end
			end
			CTPC_RESP: begin
				if (s_axi_rready) begin
					next_rd_state = CTPC_IDLE;
				end
			end
			default: next_rd_state = CTPC_IDLE;
		endcase
	end

	// Timer, cycle counter, config and interrupt next values
	always_comb begin
		logic [31:0] wv;
		logic [31:0] wt;
		logic [31:0] wm;
		wv                 = wmask(32'h0, w_data, w_strb);
		wt                 = wmask({1'b0, tick_interval}, w_data, w_strb);
		wm                 = wmask({23'h0, irq_mask}, w_data, w_strb);
		next_tick_interval = tick_interval;
		next_tick_en       = tick_en;
		next_tick_count    = tick_count;
		next_cycle         = cycle + 64'h1; // RL3
		next_irq_status    = irq_status;
		next_irq_mask      = irq_mask;
		for (int i = 0; i < PERF_N; i++) begin
			next_perf_sel[i] = perf_sel[i];
		end
		for (int i = 0; i < WATCH_N; i++) begin
			next_watch_val[i] = watch_val[i];
			next_watch_msk[i] = watch_msk[i];
		end
		// Tick timer counts down and reloads at zero
		if (tick_en) begin
			if (tick_count == '0) begin
				next_tick_count = tick_interval; // RL2
			end else begin
				next_tick_count = tick_count - 31'h1; // RL1
			end
		end
		// Read of status clears it; new events set and win
		if (do_read && s_axi_araddr == OFF_IRQ_STATUS) begin
			next_irq_status = '0;
		end
		if (do_write && aw_addr == OFF_TICK_CTRL && wv[CTRL_ACK_BIT]) begin
			next_irq_status[IRQ_TICK_BIT] = 1'b0; // RL13
		end
		if (do_write) begin
			case (aw_addr)
				OFF_TICK_INTERVAL: begin
					next_tick_interval = wt[TICK_W-1:0]; // RL2
					next_tick_count    = next_tick_interval;
					next_irq_status[IRQ_TICK_BIT] = 1'b0; // RL13
				end
				OFF_TICK_CTRL:  next_tick_en = wv[CTRL_EN_BIT];
				OFF_CYC_LO: begin
					if (aw_priv) begin
						next_cycle[31:0] = wmask(cycle[31:0], w_data, w_strb); // RL5
					end
				end
				OFF_CYC_HI: begin
					if (aw_priv) begin
						next_cycle[63:32] = wmask(cycle[63:32], w_data, w_strb); // RL5 RL6
					end
				end
				OFF_IRQ_MASK:   next_irq_mask = wm[IRQ_W-1:0];
				default: begin
					if (aw_addr[5:4] == 2'h3 && aw_addr[7:6] == 2'h0) begin
						next_perf_sel[aw_addr[3:2]] = wv[SEL_W-1:0]; // RL8
					end else if (aw_addr[7:4] == 4'h4) begin
						next_watch_val[aw_addr[3:2]] = wmask(watch_val[aw_addr[3:2]], w_data, w_strb);
					end else if (aw_addr[7:4] == 4'h5) begin
						next_watch_msk[aw_addr[3:2]] = wmask(watch_msk[aw_addr[3:2]], w_data, w_strb);
					end
				end
			endcase
		end
		if (tick_en && tick_count == 31'h1) begin
			next_irq_status[IRQ_TICK_BIT] = 1'b1; // RL1 RL13
		end
		next_irq_status[IRQ_PERF_LSB +: PERF_N] = next_irq_status[IRQ_PERF_LSB +: PERF_N] | perf_ovf; // RL10 RL12
		next_irq_status[IRQ_WATCH_LSB +: WATCH_N] = next_irq_status[IRQ_WATCH_LSB +: WATCH_N] | wif.hit;
		next_irq = |(next_irq_status & next_irq_mask);
	end

	// Register all state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_interval <= TICK_INTERVAL_RST;
			tick_count    <= TICK_INTERVAL_RST;
			tick_en       <= 1'b0;
			cycle         <= CYC_RST; // RL4
			irq_status    <= '0;
			irq_mask      <= '0;
			irq           <= 1'b0;
			for (int i = 0; i < PERF_N; i++) begin
				perf_sel[i] <= '0;
			end
			for (int i = 0; i < WATCH_N; i++) begin
				watch_val[i] <= '0;
				watch_msk[i] <= '0;
			end
			wr_state      <= CTPC_IDLE;
			rd_state      <= CTPC_IDLE;
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			aw_addr       <= '0;
			aw_priv       <= 1'b0;
			w_data        <= '0;
			w_strb        <= '0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_rresp   <= RESP_OKAY;
			s_axi_rdata   <= '0;
		end else begin
			tick_interval <= next_tick_interval;
			tick_count    <= next_tick_count;
			tick_en       <= next_tick_en;
			cycle         <= next_cycle;
			irq_status    <= next_irq_status;
			irq_mask      <= next_irq_mask;
			irq           <= next_irq;
			perf_sel      <= next_perf_sel;
			watch_val     <= next_watch_val;
			watch_msk     <= next_watch_msk;
			wr_state      <= next_wr_state;
			rd_state      <= next_rd_state;
			aw_got        <= next_aw_got;
			w_got         <= next_w_got;
			aw_addr       <= next_aw_addr;
			aw_priv       <= next_aw_priv;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			s_axi_bresp   <= next_bresp;
			s_axi_rresp   <= next_rresp;
			s_axi_rdata   <= next_rdata;
		end
	end

	// Handshake outputs from state flops
	assign s_axi_awready = !aw_got && wr_state == CTPC_IDLE;
	assign s_axi_wready  = !w_got && wr_state == CTPC_IDLE;
	assign s_axi_bvalid  = wr_state == CTPC_RESP;
	assign s_axi_arready = rd_state == CTPC_IDLE;
	assign s_axi_rvalid  = rd_state == CTPC_RESP;
endmodule // ctpc_top
`default_nettype wire

/* include/ctpc_pkg.sv */
package ctpc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_TICK_INTERVAL = 8'h00;
	localparam logic [7:0] OFF_TICK_COUNT    = 8'h04;
	localparam logic [7:0] OFF_TICK_CTRL     = 8'h08;
	localparam logic [7:0] OFF_CYC_LO        = 8'h0c;
	localparam logic [7:0] OFF_CYC_HI        = 8'h10;
	localparam logic [7:0] OFF_IRQ_STATUS    = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK      = 8'h18;
	localparam logic [7:0] OFF_PRIV_LEVEL    = 8'h1c;
	localparam logic [7:0] OFF_PERF_CNT0     = 8'h20;
	localparam logic [7:0] OFF_PERF_SEL0     = 8'h30;
	localparam logic [7:0] OFF_WATCH_VAL0    = 8'h40;
	localparam logic [7:0] OFF_WATCH_MSK0    = 8'h50;
	// Sizes
	localparam int TICK_W     = 31;
	localparam int CYC_W      = 64;
	localparam int PERF_N     = 4;
	localparam int PERF_W     = 32;
	localparam int EVT_N      = 16;
	localparam int SEL_W      = 4;
	localparam int WATCH_N    = 4;
	localparam int WATCH_W    = 32;
	// Field positions
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_ACK_BIT  = 1;
	localparam int IRQ_TICK_BIT  = 0;
	localparam int IRQ_PERF_LSB  = 1;
	localparam int IRQ_WATCH_LSB = 5;
	localparam int IRQ_W         = 9;
	// Reset values
	localparam logic [TICK_W-1:0] TICK_INTERVAL_RST = 31'h0000_0000;
	localparam logic [CYC_W-1:0]  CYC_RST           = 64'h0;
	localparam logic [1:0]        RESP_OKAY         = 2'h0;
	localparam logic [1:0]        RESP_SLVERR       = 2'h2;
	// Bus slave states
	typedef enum logic [1:0] {
		CTPC_IDLE = 2'b00,
		CTPC_RESP = 2'b01
	} ctpc_bus_state_type;
endpackage

/* include/ctpc_watch_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Watch comparator bundle: values to watch, settings and match pulses
interface ctpc_watch_if;
	logic [ctpc_pkg::WATCH_N*ctpc_pkg::WATCH_W-1:0] sample;
	logic [ctpc_pkg::WATCH_N*ctpc_pkg::WATCH_W-1:0] value;
	logic [ctpc_pkg::WATCH_N*ctpc_pkg::WATCH_W-1:0] mask;
	logic [ctpc_pkg::WATCH_N-1:0]                   hit;
	modport ctrl (output sample, output value, output mask, input hit);
	modport unit (input sample, input value, input mask, output hit);
endinterface
`default_nettype wire

/* hw/ctpc_watch.sv */
`timescale 1ns/1ps
`default_nettype none
module ctpc_watch (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Comparator bundle
	ctpc_watch_if.unit w
);
	import ctpc_pkg::*;
	logic [WATCH_N-1:0] hit_q;
	logic [WATCH_N-1:0] next_hit;

	// Masked compare, registered hit on every cycle the sample matches
	always_comb begin
		for (int i = 0; i < WATCH_N; i++) begin
			next_hit[i] = ((w.sample[i*WATCH_W +: WATCH_W] ^ w.value[i*WATCH_W +: WATCH_W])
				& w.mask[i*WATCH_W +: WATCH_W]) == '0; // RL11
		end
	end

	// Register match events
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hit_q <= '0;
		end else begin
			hit_q <= next_hit;
		end
	end
	assign w.hit = hit_q;
endmodule // ctpc_watch
`default_nettype wire

/* hw/ctpc_perf.sv */
`timescale 1ns/1ps
`default_nettype none
module ctpc_perf (
	// Clock and reset
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	// Counter control
	input  wire logic [ctpc_pkg::SEL_W-1:0] sel,
	input  wire logic [ctpc_pkg::EVT_N-1:0] events,
	input  wire logic                       load,
	input  wire logic [ctpc_pkg::PERF_W-1:0] load_value,
	// Counter state
	output logic [ctpc_pkg::PERF_W-1:0]     count,
	output logic                            overflow
);
	import ctpc_pkg::*;
	logic [PERF_W-1:0] next_count;
	logic              next_overflow;

	// Count selected event, wrap to zero on overflow
	always_comb begin
		next_count    = count;
		next_overflow = 1'b0;
		if (load) begin
			next_count = load_value;
		end else if (events[sel]) begin // RL8
			next_count    = count + 32'h1; // RL9 RL12
			next_overflow = (count == {PERF_W{1'b1}}); // RL10
		end
	end

	// Register counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count    <= '0;
			overflow <= 1'b0;
		end else begin
			count    <= next_count;
			overflow <= next_overflow;
		end
	end
endmodule // ctpc_perf
`default_nettype wire

/* tb/ctpc_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module ctpc_top_props (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Write channels
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// Read channels
	input wire logic [7:0]  s_axi_araddr,
	input wire logic [2:0]  s_axi_arprot,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Interrupt
	input wire logic        irq
);
	import ctpc_pkg::*;
	logic prot_q;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Read privilege bit as sampled on the previous clock
	always_ff @(posedge aclk) begin
		prot_q <= s_axi_arprot[0];
	end
	a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq)
		else $error("outputs not idle after reset");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while answering");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid && !s_axi_awready ##1 s_axi_bvalid)
		else $error("write answer timing wrong");
	a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h60
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_priv_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_PRIV_LEVEL
		|=> s_axi_rdata == {31'h0, prot_q})
		else $error("privilege readback wrong");
endmodule // ctpc_top_props
bind ctpc_top ctpc_top_props props_u (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .irq(irq)
);
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ctpc_pkg::*;
	logic         aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic         arvalid, arready, rvalid, rready, irq;
	logic [7:0]   awaddr, araddr;
	logic [2:0]   awprot, arprot;
	logic [31:0]  wdata, rdata, rd, a0;
	logic [3:0]   wstrb;
	logic [1:0]   bresp, rresp, rs;
	logic [11:0]  ev;
	logic [127:0] ws;
	int           fails, check_count, cycles, n, iv;

	ctpc_top dut_u (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(awprot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.core_events(ev), .watch_sample(ws), .irq(irq)
	);

	// Clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Hang guard
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count = check_count + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Write cycle: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic p);
		awaddr <= a;
		wdata <= d;
		awprot <= {2'h0, p};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid && bready));
		rs = bresp;
	endtask

	// Read cycle
	task automatic rd_t(input logic [7:0] a, input logic p);
		araddr <= a;
		arprot <= {2'h0, p};
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid && rready));
		rd = rdata;
		rs = rresp;
	endtask

	task automatic idle(input int k);
		repeat (k) @(posedge aclk);
	endtask

	// Hold one event line high for k cycles
	task automatic pulse(input int i, input int k);
		ev[i] <= 1'b1;
		idle(k);
		ev[i] <= 1'b0;
		idle(1);
	endtask

	// Main sequence
	initial begin
		{awvalid, wvalid, arvalid} = 3'h0;
		{bready, rready} = 2'h3;
		{awaddr, araddr, awprot, arprot, wdata} = '0;
		wstrb = 4'hf;
		ev = 12'h0;
		ws = '0;
		{fails, check_count, cycles} = 0;
		aresetn = 1'b0;
		idle(5);
		aresetn <= 1'b1;
		idle(1);
		rd_t(OFF_CYC_HI, 1'b0); chk(rd, 32'h0, "cycle hi after reset");
		rd_t(OFF_CYC_LO, 1'b0); chk({31'h0, rd < 32'd30}, 32'h1, "cycle lo after reset");
		a0 = rd;
		idle(20);
		rd_t(OFF_CYC_LO, 1'b0); chk({31'h0, rd - a0 >= 21 && rd - a0 <= 23}, 32'h1, "cycle step");
		wr(OFF_CYC_LO, 32'h1000_0000, 1'b1);
		rd_t(OFF_CYC_LO, 1'b0); chk({31'h0, rd >= 32'h1000_0000 && rd <= 32'h1000_000a}, 32'h1, "cycle load");
		wr(OFF_CYC_HI, 32'h7, 1'b1);
		wr(OFF_CYC_HI, 32'h9, 1'b0);
		rd_t(OFF_CYC_HI, 1'b0); chk(rd, 32'h7, "user write to cycle");
		for (int p = 0; p < 2; p++) begin
			rd_t(OFF_PRIV_LEVEL, p[0]); chk(rd, 32'(p), "privilege readback");
		end
		rd_t(8'h60, 1'b1); chk({rd[31:2], rs}, {30'h0, RESP_SLVERR}, "unmapped read");
		wr(8'h60, 32'h5, 1'b1); chk({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped write");
		// Hold both answers back a few cycles: they must stand until taken
		{bready, rready} <= 2'h0;
		araddr <= OFF_CYC_HI;
		awaddr <= 8'h60;
		{arvalid, awvalid, wvalid} <= 3'h7;
		idle(1);
		{arvalid, awvalid, wvalid} <= 3'h0;
		idle(4);
		{bready, rready} <= 2'h3;
		idle(1);
		chk({28'h0, rvalid, bvalid, bresp}, {28'h0, 2'h3, RESP_SLVERR}, "answers held");
		chk(rdata, 32'h7, "read data held");
		// Each counter on its own event, distinct counts
		for (int k = 0; k < PERF_N; k++) begin
			wr(OFF_PERF_SEL0 + 8'(4 * k), 32'(2 * k + 1), 1'b1);
			wr(OFF_PERF_CNT0 + 8'(4 * k), 32'h0, 1'b1);
		end
		for (int k = 0; k < PERF_N; k++) pulse(2 * k + 1, k + 2);
		idle(3);
		for (int k = 0; k < PERF_N; k++) begin
			rd_t(OFF_PERF_CNT0 + 8'(4 * k), 1'b0); chk(rd, 32'(k + 2), "event count");
		end
		// Overflow of counter 2
		wr(OFF_IRQ_MASK, 32'h8, 1'b1);
		rd_t(OFF_IRQ_STATUS, 1'b0);
		wr(OFF_PERF_CNT0 + 8'h8, 32'hffff_ffff, 1'b1);
		chk({31'h0, irq}, 32'h0, "irq before overflow");
		pulse(5, 1);
		idle(3);
		chk({31'h0, irq}, 32'h1, "overflow irq");
		rd_t(OFF_PERF_CNT0 + 8'h8, 1'b0); chk(rd, 32'h0, "wrap to zero");
		idle(5);
		chk({31'h0, irq}, 32'h1, "overflow pending");
		rd_t(OFF_IRQ_STATUS, 1'b0); chk(rd & 32'h8, 32'h8, "overflow status");
		idle(3);
		chk({31'h0, irq}, 32'h0, "irq cleared by read");
		// Watch comparator feeding counter 0
		wr(OFF_WATCH_VAL0, 32'h1234, 1'b1);
		wr(OFF_WATCH_MSK0, 32'hffff_ffff, 1'b1);
		wr(OFF_PERF_SEL0, 32'hc, 1'b1);
		wr(OFF_PERF_CNT0, 32'h0, 1'b1);
		rd_t(OFF_IRQ_STATUS, 1'b0);
		ws[31:0] <= 32'h1234;
		idle(3);
		ws[31:0] <= 32'h0;
		idle(4);
		rd_t(OFF_PERF_CNT0, 1'b0); chk(rd, 32'h3, "watch hits");
		rd_t(OFF_IRQ_STATUS, 1'b0); chk(rd & 32'h20, 32'h20, "watch status");
		// Tick timer at two intervals
		wr(OFF_IRQ_MASK, 32'h1, 1'b1);
		for (int i = 0; i < 2; i++) begin
			iv = (i == 0) ? 8 : 40;
			wr(OFF_TICK_CTRL, 32'h0, 1'b1);
			wr(OFF_TICK_INTERVAL, 32'(iv), 1'b1);
			rd_t(OFF_IRQ_STATUS, 1'b0);
			idle(2);
			chk({31'h0, irq}, 32'h0, "tick idle");
			wr(OFF_TICK_CTRL, 32'h1, 1'b1);
			n = 0;
			while (irq !== 1'b1 && n < 200) begin
				idle(1);
				n = n + 1;
			end
			chk({31'h0, n >= iv - 6 && n <= iv + 4}, 32'h1, "tick spacing");
			rd_t(OFF_TICK_COUNT, 1'b0); chk({31'h0, rd <= 32'(iv)}, 32'h1, "tick count");
			rd_t(OFF_IRQ_STATUS, 1'b0); chk(rd & 32'h1, 32'h1, "tick status");
			wr(OFF_TICK_CTRL, 32'h2, 1'b1);
			rd_t(OFF_IRQ_STATUS, 1'b0);
			idle(iv + 4);
			chk({31'h0, irq}, 32'h0, "tick stopped");
		end
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
